// [include/coax_pkg.sv]
// constants for the coax line pulse-width serdes and read dma
// Notes on behaviour
// - zero 210 ns, one 630 ns, sample 420 ns
// - eight-stage delay register finds each rising edge
// - one-tick sample pulse, then delay register clears
// - guard latch blocks second sample on long one
// - final stage high after twelfth pulse marks character
// - strobe masked around shift pulse; clear on fall
// - data characters stretch strobe two extra ticks
// - data character moves sampling to late tap
// - transmit-active disables receive edge detection
// - poll or read loads reply; others clear
// - transmit only answers poll or read
// - fifteen-tick bit timer, reset by each receive pulse
// - poll sets load mode; thirteenth pulse starts transmit
// - first transmit pulse loads; shift clock ORed
// - encoder drives zero strobe, adds one strobe
// - twelfth transmit pulse ends poll, sends parity
// - thirteenth pulse empties shifter; strobe end stops
// - read streams 1920 characters, then stops
// - read selects dma path and zeroes counter
// - load request stretches memory cycle on phase four
// - dma step advances counter, selects buffer data
// - later characters start dma in bits twelve-thirteen
// - parity clears on load, toggles per one
package coax_pkg;
  // clock rates in mhz
  localparam int MCLK_MHZ = 50;
  localparam int SAMPLE_MHZ = 17;
  // system clocks per sampling tick, rounded to nearest
  localparam int TICK_DIV = (MCLK_MHZ + SAMPLE_MHZ / 2) / SAMPLE_MHZ;
  // nominal line pulse widths and sample point
  localparam int ZERO_PULSE_NS = 210;
  localparam int ONE_PULSE_NS = 630;
  localparam int SAMPLE_POINT_NS = 420;
  // transmit strobe widths
  localparam int ONE_STROBE_NS = 670;
  localparam int ZERO_STROBE_NS = 180;
  localparam logic [3:0] ONE_STROBE_TICKS =
    4'(ONE_STROBE_NS * SAMPLE_MHZ / 1000);
  localparam logic [3:0] ZERO_STROBE_TICKS =
    4'(ZERO_STROBE_NS * SAMPLE_MHZ / 1000);
  // transmit bit period in ticks, last count value
  localparam logic [3:0] BIT_LAST = 4'he;
  // delay register and tap positions
  localparam int DLY_STAGES = 8;
  localparam int EARLY_TAP = 5;
  localparam int LATE_TAP = 7;
  // character framing
  localparam int SHIFT_W = 12;
  localparam logic [3:0] CHAR_BITS = 4'hc;
  localparam logic [3:0] TX_DATA_LAST = 4'hb;
  localparam logic [3:0] TX_PARITY_BIT = 4'hc;
  localparam logic [3:0] TX_LAST_BIT = 4'hd;
  // strobe stretch for data characters, in ticks
  localparam logic [1:0] EXT_TICKS = 2'h2;
  // read transfer shape
  localparam int READ_CHARS = 1920;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 10;
endpackage

// [tb/coax_cu_model.sv]
// control unit model: sends coax characters, decodes reply pulses
`timescale 1ns/1ps
module coax_cu_model #(
  parameter int BIT_CYC  = 45, // mclk per line bit
  parameter int ZERO_CYC = 11, // zero pulse width
  parameter int ONE_CYC  = 32  // one pulse width
) (
  input  wire logic mclk_i,
  input  wire logic line_tx_i,
  output logic      line_rx_o
);
  logic [11:0] shift_word = 12'h000; // reply bits so far
  int          bit_cnt    = 0;       // reply bits collected
  int          hi_cnt     = 0;       // width of current pulse
  logic [12:0] got_q[$];             // complete reply characters
  initial line_rx_o = 1'b0;          // line idles low

  // pulse-width coding of one character, first bit first
  task automatic send_char(input logic [12:0] w);
    for (int i = 12; i >= 0; i--) begin
      for (int c = 0; c < BIT_CYC; c++) begin
        @(posedge mclk_i);
        line_rx_o <= (c < (w[i] ? ONE_CYC : ZERO_CYC));
      end
    end
  endtask

  // forget earlier replies
  task automatic clear_rx();
    got_q.delete();
    bit_cnt = 0;
  endtask

  // pulse width decides each reply bit
  always @(posedge mclk_i) begin
    if (line_tx_i) begin
      hi_cnt <= hi_cnt + 1;
    end else if (hi_cnt != 0) begin
      hi_cnt <= 0;
      if (bit_cnt == 12) begin // thirteenth bit ends a character
        got_q.push_back({shift_word, hi_cnt > 20});
        bit_cnt <= 0;
      end else begin
        shift_word <= {shift_word[10:0], hi_cnt > 20};
        bit_cnt <= bit_cnt + 1;
      end
    end
  end
endmodule

// [tb/coax_serdes_bench.sv]
// self-checking bench: receive, poll reply and read stream
`timescale 1ns/1ps
module coax_serdes_bench;
  localparam int NCH = 3; // shortened read length
  logic        mclk, srst, line_rx, line_tx, tx_active, char_in;
  logic        cmd_poll, cmd_read, cmd_data, poll_pend, read_pend;
  logic        sh_empty, dma_sel, dma_clr, stretch, step;
  logic        phase4      = 1'b0;   // memory phase four
  logic [1:0]  ph          = 2'h0;   // memory phase counter
  logic [9:0]  status_word = 10'h3c5;
  logic [9:0]  buf_data    = 10'h000;
  logic [11:0] rx_char, got_char;
  logic [10:0] dma_addr;
  logic        ch_prev = 1'b0, seen_clr = 1'b0, seen_sel = 1'b0;
  int          fail_count = 0, n_compared = 0, ch_w = 0, wa;

  coax_serdes #(.READ_CHARS(NCH)) i_dut (
    .mclk_i(mclk), .srst_i(srst), .line_rx_i(line_rx),
    .cmd_poll_i(cmd_poll), .cmd_read_i(cmd_read), .cmd_data_i(cmd_data),
    .status_word_i(status_word), .buf_data_i(buf_data),
    .phase4_i(phase4), .line_tx_o(line_tx), .tx_active_o(tx_active),
    .rx_char_o(rx_char), .char_in_o(char_in),
    .poll_pending_o(poll_pend), .read_pending_o(read_pend),
    .shifter_empty_flag_o(sh_empty), .dma_select_o(dma_sel),
    .dma_clear_o(dma_clr), .dma_cycle_stretch_o(stretch),
    .dma_step_o(step), .dma_addr_o(dma_addr));
  coax_cu_model i_cu (.mclk_i(mclk), .line_tx_i(line_tx),
    .line_rx_o(line_rx));

  // line character: start, payload, odd parity, closing zero
  function automatic logic [12:0] frame(input logic [9:0] d);
    return {1'b1, d, ^d, 1'b0};
  endfunction
  // buffer contents as a function of address
  function automatic logic [9:0] buf_val(input logic [10:0] a);
    return 10'(a * 11'h07b) ^ 10'h2c3;
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // wait for transmit to end, bounded by the run timeout
  task automatic wait_tx_done();
    while (tx_active !== 1'b0) @(posedge mclk);
    repeat (5) @(posedge mclk);
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // memory phases, buffer data and strobe width capture
  always @(posedge mclk) begin
    ph <= ph + 2'h1;
    phase4 <= (ph == 2'h2);
    buf_data <= buf_val(dma_addr);
    if (dma_clr) seen_clr <= 1'b1;
    if (dma_sel) seen_sel <= 1'b1;
    if (char_in && !ch_prev) begin
      got_char <= rx_char;
      ch_w <= 1;
    end else if (char_in) begin
      ch_w <= ch_w + 1;
    end
    ch_prev <= char_in;
  end

  // run ceiling
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    end_sim();
  end

  initial begin
    srst = 1'b1;
    cmd_poll = 1'b0;
    cmd_read = 1'b0;
    cmd_data = 1'b0;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    check(16'({line_tx, tx_active, char_in, poll_pend, read_pend,
      sh_empty, dma_sel, dma_clr, stretch, step}), 16'h0000);
    check(16'(dma_addr), 16'h0000);
    repeat (4) @(posedge mclk);
    // control character: deserialised, no reply
    i_cu.send_char(frame(10'h2a5));
    repeat (30) @(posedge mclk);
    check(16'(got_char), 16'(frame(10'h2a5) >> 1));
    check(16'(tx_active), 16'h0000);
    wa = ch_w;
    // data character: same bits, strobe two ticks longer
    cmd_data <= 1'b1;
    i_cu.send_char(frame(10'h15a));
    repeat (30) @(posedge mclk);
    cmd_data <= 1'b0;
    check(16'(got_char), 16'(frame(10'h15a) >> 1));
    check(16'(ch_w - wa), 16'h0006);
    // poll: one status character back
    cmd_poll <= 1'b1;
    i_cu.clear_rx();
    i_cu.send_char(frame(10'h0f0));
    cmd_poll <= 1'b0;
    wait_tx_done();
    check(16'(i_cu.got_q.size()), 16'h0001);
    check(16'(i_cu.got_q[0]), 16'(frame(status_word)));
    check(16'({poll_pend, sh_empty}), 16'h0001);
    // read: buffer characters streamed from address zero
    cmd_read <= 1'b1;
    i_cu.clear_rx();
    i_cu.send_char(frame(10'h0f1));
    cmd_read <= 1'b0;
    wait_tx_done();
    check(16'(i_cu.got_q.size()), 16'(NCH));
    for (int k = 0; k < NCH; k++)
      check(16'(i_cu.got_q[k]), 16'(frame(buf_val(11'(k)))));
    check(16'(dma_addr), 16'(NCH));
    check(16'({read_pend, seen_clr, seen_sel}), 16'h0003);
    end_sim();
  end
endmodule

// [tb/coax_serdes_sva.sv]
// port checker for the coax serdes, bound to the design
`timescale 1ns/1ps
module coax_serdes_sva #(
  parameter int ADDR_W     = coax_pkg::ADDR_W,
  parameter int READ_CHARS = coax_pkg::READ_CHARS
) (
  input wire logic              mclk_i,
  input wire logic              srst_i,
  input wire logic              phase4_i,
  input wire logic              line_tx_o,
  input wire logic              tx_active_o,
  input wire logic [11:0]       rx_char_o,
  input wire logic              char_in_o,
  input wire logic              poll_pending_o,
  input wire logic              read_pending_o,
  input wire logic              shifter_empty_flag_o,
  input wire logic              dma_clear_o,
  input wire logic              dma_cycle_stretch_o,
  input wire logic              dma_step_o,
  input wire logic [ADDR_W-1:0] dma_addr_o
);
  // single clock domain, reset masks every check
  default clocking main_cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  chk_line_gated: assert property (
    line_tx_o |-> tx_active_o || $past(tx_active_o))
    else $error("line driven outside transmit");
  chk_tx_reply: assert property (
    $rose(tx_active_o) |-> poll_pending_o || read_pending_o)
    else $error("transmit started without poll or read");
  chk_tx_masks_rx: assert property (
    $rose(tx_active_o) |-> !char_in_o)
    else $error("strobe still up at transmit start");
  chk_char_start: assert property (
    char_in_o |-> rx_char_o[11])
    else $error("strobe without start bit in final stage");
  chk_clear_pulse: assert property (
    dma_clear_o |=> !dma_clear_o)
    else $error("counter clear longer than one cycle");
  chk_clear_start: assert property (
    $rose(read_pending_o) |-> ##[0:2] dma_clear_o)
    else $error("read start gave no counter clear");
  chk_addr_zero: assert property (
    dma_clear_o |-> ##[0:1] (dma_addr_o == '0))
    else $error("counter not zeroed by clear");
  chk_addr_inc: assert property (
    $changed(dma_addr_o) && dma_addr_o != '0
      |-> dma_addr_o == $past(dma_addr_o) + 1'b1)
    else $error("address did not step by one");
  chk_step_fall: assert property (
    $fell(dma_step_o) |-> ##[0:1] $changed(dma_addr_o))
    else $error("step ended without address advance");
  chk_stretch_phase: assert property (
    $rose(dma_cycle_stretch_o) |-> $past(phase4_i))
    else $error("stretch not aligned to phase four");
  chk_step_stretch: assert property (
    $rose(dma_step_o) |-> dma_cycle_stretch_o)
    else $error("step without cycle stretch");
  chk_empty_tx: assert property (
    $rose(shifter_empty_flag_o) |-> tx_active_o)
    else $error("shifter empty outside transmit");
  chk_poll_clear: assert property (
    $fell(poll_pending_o) |-> tx_active_o)
    else $error("poll latch cleared outside transmit");
  chk_addr_bound: assert property (
    dma_addr_o <= READ_CHARS)
    else $error("address ran past read length");
endmodule

bind coax_serdes coax_serdes_sva #(
  .ADDR_W(ADDR_W), .READ_CHARS(READ_CHARS)
) i_sva (
  .mclk_i, .srst_i, .phase4_i, .line_tx_o, .tx_active_o, .rx_char_o,
  .char_in_o, .poll_pending_o, .read_pending_o, .shifter_empty_flag_o,
  .dma_clear_o, .dma_cycle_stretch_o, .dma_step_o, .dma_addr_o
);

// [verilog/coax_serdes.sv]
// coax pwm receive/transmit serdes with read dma sequencing
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module coax_serdes #(
  parameter int DATA_W     = coax_pkg::DATA_W,
  parameter int ADDR_W     = coax_pkg::ADDR_W,
  parameter int READ_CHARS = coax_pkg::READ_CHARS
) (
  input  wire logic              mclk_i,
  input  wire logic              srst_i,
  input  wire logic              line_rx_i,
  input  wire logic              cmd_poll_i,
  input  wire logic              cmd_read_i,
  input  wire logic              cmd_data_i,
  input  wire logic [DATA_W-1:0] status_word_i,
  input  wire logic [DATA_W-1:0] buf_data_i,
  input  wire logic              phase4_i,
  output logic                   line_tx_o,
  output logic                   tx_active_o,
  output logic [11:0]            rx_char_o,
  output logic                   char_in_o,
  output logic                   poll_pending_o,
  output logic                   read_pending_o,
  output logic                   shifter_empty_flag_o,
  output logic                   dma_select_o,
  output logic                   dma_clear_o,
  output logic                   dma_cycle_stretch_o,
  output logic                   dma_step_o,
  output logic [ADDR_W-1:0]      dma_addr_o
);

  // sampling tick generator
  logic [1:0]  tick_cnt;      // system clocks within a tick
  logic        tick;          // one-clock tick marker
  // receive front end
  logic        line_s;        // registered line level
  logic [7:0]  dly;           // edge delay register
  logic        guard_latch;   // blocks re-entry of a long one
  logic        samp;          // sample pulse, one tick wide
  logic        late_sel;      // sample from late tap
  logic [3:0]  rx_cnt;        // receive pulses in this character
  // shifter and transmit state
  logic [11:0] sh;            // serializer/deserializer
  logic        load_mode;     // next shift clock loads
  logic        load_req;      // buffer fetch wanted
  logic [3:0]  bit_timer;     // transmit bit width counter
  logic [3:0]  tx_bit;        // transmit bit number, 0 before load
  logic        par;           // running transmit parity
  logic        par_bit;       // parity bit to send
  logic        src_buf;       // reply source is buffer
  logic [10:0] char_cnt;      // read characters sent
  logic        read_q;        // read pending, delayed

  // tap selection and decode terms
  wire         tap_sel;       // selected sampling tap
  wire         pre_sel;       // stage ahead of selected tap
  wire         rx_shift;      // receive shift event
  wire         rx_last;       // thirteenth receive shift event
  wire         tx_pulse;      // transmit shift event
  wire         shift_clk;     // combined shifter clock
  wire         mask;          // strobe mask window
  wire         char_now;      // unmasked character complete
  wire         strobe_next;   // next strobe level
  wire         strobe_fall;   // strobe about to drop
  wire         strobe_end;    // end of one strobe in last bit
  wire         last_char;     // this read character is final
  wire         cur_bit;       // bit being transmitted
  wire         one_s;         // one strobe active
  wire         zero_s;        // zero strobe active
  wire         next_line;     // encoded line level
  wire         read_rise;     // read pending just set
  wire [DATA_W-1:0] load_word; // parallel reply source

  // late tap once a data character is decoded
  assign tap_sel = late_sel ? dly[coax_pkg::LATE_TAP]
                            : dly[coax_pkg::EARLY_TAP];
  assign pre_sel = late_sel ? dly[coax_pkg::LATE_TAP - 1]
                            : dly[coax_pkg::EARLY_TAP - 1];
  // a sample fires on the tap's first tick, never while sending
  assign rx_shift = tick & tap_sel & ~samp & ~tx_active_o;
  assign rx_last = rx_shift & (rx_cnt == coax_pkg::CHAR_BITS);
  assign tx_pulse = tick & tx_active_o
                    & (bit_timer == coax_pkg::BIT_LAST);
  assign shift_clk = rx_shift | tx_pulse;
  // mask one tick ahead of and during the shift pulse
  assign mask = pre_sel | samp;
  assign char_now = sh[coax_pkg::SHIFT_W - 1] & ~mask
                    & (rx_cnt == coax_pkg::CHAR_BITS);
  assign strobe_next = char_now;
  assign strobe_fall = char_in_o & ~strobe_next;
  assign strobe_end = tick & tx_active_o
                      & (tx_bit == coax_pkg::TX_LAST_BIT)
                      & (bit_timer == coax_pkg::ONE_STROBE_TICKS);
  assign last_char = (char_cnt == 11'(READ_CHARS - 1));
  // data bits, then parity, then a zero thirteenth bit
  assign cur_bit = (tx_bit == coax_pkg::TX_PARITY_BIT) ? par_bit
                 : (tx_bit == coax_pkg::TX_LAST_BIT) ? 1'b0
                 : sh[coax_pkg::SHIFT_W - 1];
  assign one_s = bit_timer < coax_pkg::ONE_STROBE_TICKS;
  assign zero_s = bit_timer < coax_pkg::ZERO_STROBE_TICKS;
  // zero strobe always, one strobe added for ones
  assign next_line = tx_active_o & ~samp & (tx_bit != 4'h0)
                     & (zero_s | (one_s & cur_bit));
  assign read_rise = read_pending_o & ~read_q;
  assign load_word = src_buf ? buf_data_i : status_word_i;

  // tick divider for the sampling rate
  always_ff @(posedge mclk_i) begin
    if (srst_i || tick_cnt == 2'(coax_pkg::TICK_DIV - 1)) begin
      tick_cnt <= 2'h0;
    end else begin
      tick_cnt <= tick_cnt + 2'h1;
    end
  end
  always_ff @(posedge mclk_i) begin
    tick <= ~srst_i & (tick_cnt == 2'(coax_pkg::TICK_DIV - 1));
  end

  // register the incoming line level
  always_ff @(posedge mclk_i) begin
    line_s <= srst_i ? 1'b0 : line_rx_i;
  end

  // edge delay register, cleared after each sample
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      dly <= 8'h00;
    end else if (tick) begin
      if (samp || tx_active_o) begin
        dly <= 8'h00;
      end else begin
        dly <= {dly[6:0], line_s & guard_latch};
      end
    end
  end

  // guard latch, rearmed only when the line goes low
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      guard_latch <= 1'b1;
    end else if (tick) begin
      if (samp || tx_active_o) begin
        guard_latch <= 1'b0;
      end else if (!line_s) begin
        guard_latch <= 1'b1;
      end
    end
  end

  // sample pulse lasts exactly one tick
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      samp <= 1'b0;
    end else if (tick) begin
      samp <= tap_sel & ~samp & ~tx_active_o;
    end
  end

  // receive pulse count and tap choice
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rx_cnt <= 4'h0;
      late_sel <= 1'b0;
    end else begin
      if (rx_last) begin
        rx_cnt <= 4'h0;
        late_sel <= 1'b0;
      end else if (rx_shift) begin
        rx_cnt <= rx_cnt + 4'h1;
      end
      if (char_now && cmd_data_i) begin
        // later tap moves the mask, holding the strobe two ticks
        late_sel <= 1'b1;
      end
    end
  end

  // character strobe and held parallel data
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      char_in_o <= 1'b0;
      rx_char_o <= 12'h000;
    end else begin
      char_in_o <= strobe_next;
      if (char_now) begin
        rx_char_o <= sh;
      end
    end
  end

  // shifter: load, empty, shift, or clear after a character
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sh <= 12'h000;
    end else if (shift_clk && load_mode) begin
      sh <= {1'b1, load_word, 1'b0};
    end else if (tx_pulse && tx_bit == coax_pkg::TX_PARITY_BIT) begin
      sh <= 12'h000;
    end else if (shift_clk) begin
      sh <= {sh[10:0], ~tx_active_o & line_s};
    end else if (strobe_fall && !load_mode) begin
      sh <= 12'h000;
    end
  end

  // load mode: set by a reply or the next read character
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      load_mode <= 1'b0;
    end else if (char_now && (cmd_poll_i || cmd_read_i)) begin
      load_mode <= 1'b1;
    end else if (tx_pulse && load_mode) begin
      load_mode <= 1'b0;
    end else if (tx_pulse && tx_bit == coax_pkg::TX_PARITY_BIT) begin
      load_mode <= read_pending_o & ~last_char;
    end
  end

  // poll and read pending latches
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      poll_pending_o <= 1'b0;
      read_pending_o <= 1'b0;
    end else begin
      if (char_now && cmd_poll_i) begin
        poll_pending_o <= 1'b1;
      end else if (tx_pulse && tx_bit == coax_pkg::TX_DATA_LAST) begin
        poll_pending_o <= 1'b0;
      end
      if (char_now && cmd_read_i) begin
        read_pending_o <= 1'b1;
      end else if (tx_pulse && tx_bit == coax_pkg::TX_PARITY_BIT
                   && last_char) begin
        read_pending_o <= 1'b0;
      end
    end
  end

  // transmit-active latch
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      tx_active_o <= 1'b0;
    end else if (rx_last && load_mode) begin
      tx_active_o <= 1'b1;
    end else if (strobe_end && !load_mode) begin
      tx_active_o <= 1'b0;
    end
  end

  // bit width counter, restarted by each receive pulse
  always_ff @(posedge mclk_i) begin
    if (srst_i || rx_shift) begin
      bit_timer <= 4'h0;
    end else if (tick) begin
      bit_timer <= (bit_timer == coax_pkg::BIT_LAST) ? 4'h0
                                                     : bit_timer + 4'h1;
    end
  end

  // transmit bit number
  always_ff @(posedge mclk_i) begin
    if (srst_i || (rx_last && load_mode)) begin
      tx_bit <= 4'h0;
    end else if (tx_pulse) begin
      tx_bit <= load_mode ? 4'h1 : tx_bit + 4'h1;
    end
  end

  // serial parity over bits one to eleven
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      par <= 1'b0;
      par_bit <= 1'b0;
    end else if (tx_pulse) begin
      if (load_mode) begin
        par <= 1'b0;
      end else if (tx_bit <= coax_pkg::TX_DATA_LAST) begin
        par <= par ^ sh[coax_pkg::SHIFT_W - 1];
      end
      if (tx_bit == coax_pkg::TX_DATA_LAST) begin
        // odd parity across bits one to twelve
        par_bit <= ~(par ^ sh[coax_pkg::SHIFT_W - 1]);
      end
    end
  end

  // shifter-empty flag
  always_ff @(posedge mclk_i) begin
    if (srst_i || (shift_clk && load_mode)) begin
      shifter_empty_flag_o <= 1'b0;
    end else if (tx_pulse && tx_bit == coax_pkg::TX_PARITY_BIT) begin
      shifter_empty_flag_o <= 1'b1;
    end
  end

  // registered line driver
  always_ff @(posedge mclk_i) begin
    line_tx_o <= srst_i ? 1'b0 : next_line;
  end

  // read character count and address path select
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      read_q <= 1'b0;
      dma_select_o <= 1'b0;
      dma_clear_o <= 1'b0;
      char_cnt <= 11'h000;
    end else begin
      read_q <= read_pending_o;
      dma_select_o <= read_pending_o;
      dma_clear_o <= read_rise;
      if (read_rise) begin
        char_cnt <= 11'h000;
      end else if (tx_pulse && tx_bit == coax_pkg::TX_PARITY_BIT) begin
        char_cnt <= char_cnt + 11'h001;
      end
    end
  end

  // buffer fetch request: first on read, then in bits 12-13
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      load_req <= 1'b0;
    end else if (read_rise) begin
      load_req <= 1'b1;
    end else if (tx_pulse && tx_bit == coax_pkg::TX_DATA_LAST
                 && read_pending_o && !last_char) begin
      load_req <= 1'b1;
    end else if (load_req && phase4_i) begin
      load_req <= 1'b0;
    end
  end

  // cycle stretch and step, held until the shifter loads
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      dma_cycle_stretch_o <= 1'b0;
      dma_step_o <= 1'b0;
    end else if (load_req && phase4_i) begin
      dma_cycle_stretch_o <= 1'b1;
      dma_step_o <= 1'b1;
    end else if (tx_pulse && load_mode) begin
      dma_cycle_stretch_o <= 1'b0;
      dma_step_o <= 1'b0;
    end
  end

  // address counter: zeroed on read, stepped on step trailing edge
  always_ff @(posedge mclk_i) begin
    if (srst_i || read_rise) begin
      dma_addr_o <= '0;
    end else if (dma_step_o && tx_pulse && load_mode) begin
      dma_addr_o <= dma_addr_o + ADDR_W'(1);
    end
  end

  // reply source: buffer once stepped, status otherwise
  always_ff @(posedge mclk_i) begin
    if (srst_i || (strobe_end && !load_mode)) begin
      src_buf <= 1'b0;
    end else if (load_req && phase4_i) begin
      src_buf <= 1'b1;
    end
  end

endmodule
